/* srs_agent_end.sv */
// agent end: pacing, external requests and read responses
`timescale 1ns/1ps
`default_nettype none
module srs_agent_end (
   input wire logic clk,
   input wire logic rst_n,
   srs_sysbus_if.agent bus,
   input wire logic rdAccept,
   input wire logic wrAccept,
   input wire logic extValid,
   output logic extReady,
   input wire srs_pkg::srs_ext_kind_t extKind,
   input wire logic [srs_pkg::AD_W-1:0] extAddr,
   input wire logic [srs_pkg::AD_W-1:0] extData,
   output logic extRdValid,
   output logic [srs_pkg::AD_W-1:0] extRdData,
   output logic extRdErr,
   output logic prqValid,
   output logic prqWrite,
   output logic [srs_pkg::SIZE_W-1:0] prqSize,
   output logic [srs_pkg::AD_W-1:0] prqAddr,
   output logic pwValid,
   output logic [srs_pkg::AD_W-1:0] pwData,
   output logic pwLast,
   input wire logic rspValid,
   output logic rspReady,
   input wire logic [srs_pkg::AD_W-1:0] rspData,
   input wire logic rspErr,
   input wire logic rspLast
);
   localparam int SW = 2 + srs_pkg::CMD_W + srs_pkg::AD_W;

   typedef enum logic [2:0] {
      A_IDLE = 3'b000,
      A_ASK = 3'b001,
      A_ADDR = 3'b011,
      A_DATA = 3'b010,
      A_WAITANS = 3'b110,
      A_RSP = 3'b111
   } srs_astate_t;

   srs_astate_t state_q;
   logic [SW-1:0] sync1_q;
   logic [SW-1:0] sync2_q;
   logic readPending_q;
   logic slaveOk_q;
   logic voutN;
   logic relN;
   logic [srs_pkg::CMD_W-1:0] cmdIn;
   logic [srs_pkg::AD_W-1:0] adIn;
   logic procAddr;
   logic procData;
   logic [7:0] hist_q;
   logic procIssue;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sync1_q <= {2'h3, {(SW-2){1'b0}}};
         sync2_q <= {2'h3, {(SW-2){1'b0}}};
         hist_q <= '0;
      end else begin
         sync1_q <= {bus.processorCycleValidN, bus.busReleaseN,
            bus.sysCommandBus, bus.sysAddrDataBus};
         sync2_q <= sync1_q;
         hist_q <= {hist_q[5:0], !bus.writeAcceptReadyN,
            !bus.readAcceptReadyN};
      end
   end

   assign {voutN, relN, cmdIn, adIn} = sync2_q;
   assign procAddr = !voutN && !cmdIn[srs_pkg::CMD_DATA_BIT];
   assign procData = !voutN && cmdIn[srs_pkg::CMD_DATA_BIT];
   // only the issue cycle counts: own ready four edges before it is seen
   assign procIssue = procAddr
      && hist_q[{2'h3, cmdIn[srs_pkg::CMD_WRITE_BIT]}]; // see [RULE10] [RULE12]

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= A_IDLE;
      end else begin
         case (state_q)
            A_IDLE: begin
               // responses first
               if (slaveOk_q && rspValid) state_q <= A_RSP;
               else if (extValid) state_q <= slaveOk_q ? A_ADDR : A_ASK;
            end
            A_ASK: if (!relN) state_q <= A_ADDR;
            A_ADDR: begin
               if (extKind == srs_pkg::EXT_WRITE) state_q <= A_DATA;
               else if (extKind == srs_pkg::EXT_READ) state_q <= A_WAITANS;
               else state_q <= A_IDLE;
            end
            A_DATA: state_q <= A_IDLE;
            A_WAITANS: if (procData) state_q <= A_IDLE;
            A_RSP: if (rspValid && rspLast) state_q <= A_IDLE;
            default: state_q <= A_IDLE;
         endcase
      end
   end

   // release after a read: self shift
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         readPending_q <= 1'b0;
         slaveOk_q <= 1'b0;
      end else if (state_q == A_RSP && rspValid && rspLast) begin
         readPending_q <= 1'b0;
         slaveOk_q <= 1'b0;
      end else begin
         if (procIssue && !cmdIn[7]) readPending_q <= 1'b1;
         if (!relN && (readPending_q || procAddr)) slaveOk_q <= 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prqValid <= 1'b0;
         prqWrite <= 1'b0;
         prqSize <= '0;
         prqAddr <= '0;
         pwValid <= 1'b0;
         pwData <= '0;
         pwLast <= 1'b0;
         extRdValid <= 1'b0;
         extRdData <= '0;
         extRdErr <= 1'b0;
      end else begin
         prqValid <= procIssue;
         if (procIssue) begin
            prqWrite <= cmdIn[srs_pkg::CMD_WRITE_BIT];
            prqSize <= cmdIn[srs_pkg::SIZE_LSB +: srs_pkg::SIZE_W];
            prqAddr <= adIn;
         end
         pwValid <= procData && (state_q != A_WAITANS);
         if (procData) begin
            pwData <= adIn;
            pwLast <= cmdIn[srs_pkg::ID_LAST_BIT];
         end
         extRdValid <= (state_q == A_WAITANS) && procData;
         if ((state_q == A_WAITANS) && procData) begin
            extRdData <= adIn;
            extRdErr <= cmdIn[srs_pkg::ID_ERR_BIT];
         end
      end
   end

   assign extReady = (state_q == A_ADDR);
   assign rspReady = (state_q == A_RSP);
   assign bus.externalBusRequestN = !(state_q == A_ASK);
   // ready held off while asking, so the request leads the ready
   assign bus.readAcceptReadyN = !(rdAccept && state_q != A_ASK);
   assign bus.writeAcceptReadyN = !(wrAccept && state_q != A_ASK);
   assign bus.agentOe = (state_q == A_ADDR) || (state_q == A_DATA)
      || (state_q == A_RSP);
   assign bus.agentCycleValidN = !((state_q == A_ADDR)
      || (state_q == A_DATA) || (state_q == A_RSP && rspValid));
   assign bus.agentAd = (state_q == A_ADDR) ? extAddr
      : ((state_q == A_DATA) ? extData : rspData);
   assign bus.agentCmd = (state_q == A_ADDR)
      ? srs_pkg::addrCmd(extKind == srs_pkg::EXT_WRITE,
         extKind == srs_pkg::EXT_NULL, srs_pkg::SZ_WORD)
      : srs_pkg::dataId((state_q == A_RSP) && rspErr,
         (state_q == A_DATA) || rspLast);
endmodule
`default_nettype wire

/* srs_pair_buffer.sv */
// two-entry valid/ready buffer
`timescale 1ns/1ps
`default_nettype none
module srs_pair_buffer #(
   parameter int W = 32
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic inValid,
   output logic inReady,
   input wire logic [W-1:0] inData,
   output logic outValid,
   input wire logic outReady,
   output logic [W-1:0] outData
);
   logic [W-1:0] mem_q [2];
   logic wp_q;
   logic rp_q;
   logic [1:0] cnt_q;
   logic push;
   logic pop;

   assign inReady = (cnt_q != 2'h2);
   assign outValid = (cnt_q != 2'h0);
   assign outData = mem_q[rp_q];
   assign push = inValid && inReady;
   assign pop = outValid && outReady;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wp_q <= 1'b0;
         rp_q <= 1'b0;
         cnt_q <= 2'h0;
      end else begin
         if (push) wp_q <= ~wp_q;
         if (pop) rp_q <= ~rp_q;
         cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
      end
   end

   // storage needs no reset: outValid hides stale words
   always_ff @(posedge clk) begin
      if (push) mem_q[wp_q] <= inData;
   end
endmodule
`default_nettype wire

/* srs_pkg.sv */
// shared constants and types for the system bus request sequencer
package srs_pkg;
   localparam int AD_W = 32;
   localparam int CMD_W = 9;
   // command bus layout
   localparam int CMD_DATA_BIT = 8;
   localparam int CMD_WRITE_BIT = 7;
   localparam int CMD_NULL_BIT = 6;
   localparam int ID_ERR_BIT = 5;
   localparam int ID_LAST_BIT = 4;
   localparam int SIZE_LSB = 0;
   localparam int SIZE_W = 3;
   // transfer geometry and timing
   localparam int BLOCK_WORDS = 8;
   localparam int DWORD_WORDS = 2;
   localparam int COMPAT_GAP_CYCLES = 4;
   localparam int SYNC_STAGES = 2;

   typedef enum logic [2:0] {
      SZ_BLOCK = 3'h0,
      SZ_DWORD = 3'h1,
      SZ_PDWORD = 3'h2,
      SZ_WORD = 3'h3,
      SZ_PWORD = 3'h4
   } srs_size_t;

   typedef enum logic [1:0] {
      EXT_READ = 2'h0,
      EXT_WRITE = 2'h1,
      EXT_NULL = 2'h2
   } srs_ext_kind_t;

   function automatic logic [CMD_W-1:0] addrCmd(input logic wr,
      input logic nul, input srs_size_t sz);
      logic [CMD_W-1:0] c;
      c = '0;
      c[CMD_WRITE_BIT] = wr;
      c[CMD_NULL_BIT] = nul;
      c[SIZE_LSB +: SIZE_W] = sz;
      return c;
   endfunction

   function automatic logic [CMD_W-1:0] dataId(input logic err,
      input logic last);
      logic [CMD_W-1:0] c;
      c = '0;
      c[CMD_DATA_BIT] = 1'b1;
      c[ID_ERR_BIT] = err;
      c[ID_LAST_BIT] = last;
      return c;
   endfunction
endpackage

/* srs_processor_end.sv */
// processor end: request issue, ownership arbitration, responses
// Behaviour
// [RULE1] one read outstanding until its response ends
// [RULE2] compat mode: four idle cycles after writes
// [RULE3] reads carry block, dword, partial and word sizes
// [RULE4] writes carry the same five transfer sizes
// [RULE5] strictly one request at a time
// [RULE6] reads gated by read ready, writes by write ready
// [RULE7] agent serves reads, may interpose external requests
// [RULE8] read completes on last response word only
// [RULE9] error data identifier reported as bus error
// [RULE10] agent takes reads when none pending
// [RULE11] write completes after last data word
// [RULE12] agent takes writes when none pending
// [RULE13] external requests: word read, word write, null
// [RULE14] agent asks, processor pulses release once
// [RULE15] ownership returns; one external request at once
// [RULE16] idle processor picks own or external request
// [RULE17] grant allowed while waiting for ready
// [RULE18] external request allowed before read response
// [RULE19] external read answered with one data word
// [RULE20] external read answers error identifier, junk data
// [RULE21] external write lands in interrupt register port
// [RULE22] read responses need no ownership handshake
// [RULE23] command top bit: address versus data cycle
// [RULE24] address cycle repeats until ready seen earlier
`timescale 1ns/1ps
`default_nettype none
module srs_processor_end #(
   parameter int BLOCK_WORDS = srs_pkg::BLOCK_WORDS
) (
   input wire logic clk,
   input wire logic rst_n,
   srs_sysbus_if.proc bus,
   input wire logic compatMode,
   input wire logic reqValid,
   output logic reqReady,
   input wire logic reqWrite,
   input wire srs_pkg::srs_size_t reqSize,
   input wire logic [srs_pkg::AD_W-1:0] reqAddr,
   input wire logic wrValid,
   output logic wrReady,
   input wire logic [srs_pkg::AD_W-1:0] wrData,
   output logic rspValid,
   output logic [srs_pkg::AD_W-1:0] rspData,
   output logic rspLast,
   output logic busError,
   output logic intrWrValid,
   output logic [srs_pkg::AD_W-1:0] intrWrData
);
   localparam int SW = 4 + srs_pkg::CMD_W + srs_pkg::AD_W;

   typedef enum logic [2:0] {
      P_IDLE = 3'b000,
      P_ISSUE = 3'b001,
      P_WDATA = 3'b011,
      P_GAP = 3'b010,
      P_WAITRSP = 3'b110,
      P_GRANT = 3'b111,
      P_EXTANS = 3'b101,
      P_EXTWR = 3'b100
   } srs_pstate_t;

   srs_pstate_t state_q;
   srs_pstate_t retState_q;
   logic [SW-1:0] sync1_q;
   logic [SW-1:0] sync2_q;
   logic [srs_pkg::AD_W-1:0] addr_q;
   srs_pkg::srs_size_t size_q;
   logic isWrite_q;
   logic [7:0] wordsLeft_q;
   logic [2:0] gap_q;
   logic preferExt_q;
   logic release_q;
   logic rdyN;
   logic wrdyN;
   logic extN;
   logic vinN;
   logic [srs_pkg::CMD_W-1:0] cmdIn;
   logic [srs_pkg::AD_W-1:0] adIn;
   logic rdySeen;
   logic extReq;
   logic agentAddr;
   logic agentData;
   logic grantNow;
   logic wbValid;
   logic wbReady;
   logic [srs_pkg::AD_W-1:0] wbData;

   function automatic logic [7:0] wordsFor(input srs_pkg::srs_size_t sz);
      if (sz == srs_pkg::SZ_BLOCK) return 8'(BLOCK_WORDS);
      else if (sz == srs_pkg::SZ_DWORD) return 8'(srs_pkg::DWORD_WORDS);
      else return 8'h01;
   endfunction

   // agent pins pass two flops
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sync1_q <= {4'hf, {(SW-4){1'b0}}};
         sync2_q <= {4'hf, {(SW-4){1'b0}}};
      end else begin
         sync1_q <= {bus.readAcceptReadyN, bus.writeAcceptReadyN,
            bus.externalBusRequestN, bus.agentCycleValidN,
            bus.sysCommandBus, bus.sysAddrDataBus};
         sync2_q <= sync1_q;
      end
   end

   assign {rdyN, wrdyN, extN, vinN, cmdIn, adIn} = sync2_q;
   // stage two lags the pin by two edges, matching the issue rule
   assign rdySeen = isWrite_q ? !wrdyN : !rdyN; // see [RULE6] [RULE24]
   assign extReq = !extN;
   assign agentAddr = !vinN && !cmdIn[srs_pkg::CMD_DATA_BIT]; // see [RULE23]
   assign agentData = !vinN && cmdIn[srs_pkg::CMD_DATA_BIT];
   // alternate with the agent so neither side starves
   assign grantNow = extReq && (preferExt_q || !reqValid); // see [RULE16]
   assign reqReady = (state_q == P_IDLE) && !grantNow; // see [RULE5]
   assign wbReady = (state_q == P_WDATA);

   srs_pair_buffer #(.W(srs_pkg::AD_W)) u_wrbuf (
      .clk(clk),
      .rst_n(rst_n),
      .inValid(wrValid),
      .inReady(wrReady),
      .inData(wrData),
      .outValid(wbValid),
      .outReady(wbReady),
      .outData(wbData)
   );

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= P_IDLE;
         retState_q <= P_IDLE;
      end else begin
         case (state_q)
            P_IDLE: begin
               if (grantNow) begin
                  state_q <= P_GRANT; // see [RULE14]
                  retState_q <= P_IDLE;
               end else if (reqValid) begin
                  state_q <= P_ISSUE;
               end
            end
            P_ISSUE: begin
               if (extReq && !rdySeen) begin
                  state_q <= P_GRANT; // see [RULE17]
                  retState_q <= P_ISSUE;
               end else if (rdySeen) begin
                  // reads shift to slave at once to await the response
                  state_q <= isWrite_q ? P_WDATA : P_WAITRSP; // see [RULE1]
               end
            end
            P_WDATA: begin
               if (wbValid && wordsLeft_q == 8'h01) begin
                  state_q <= compatMode ? P_GAP : P_IDLE; // see [RULE11]
               end
            end
            P_GAP: begin
               if (gap_q == 3'h0) state_q <= P_IDLE; // see [RULE2]
            end
            P_WAITRSP: begin
               if (agentData && cmdIn[srs_pkg::ID_LAST_BIT]) begin
                  state_q <= P_IDLE; // see [RULE8] [RULE22]
               end else if (agentAddr) begin
                  retState_q <= P_WAITRSP; // see [RULE18] [RULE7]
                  if (cmdIn[srs_pkg::CMD_NULL_BIT]) state_q <= P_WAITRSP;
                  else if (cmdIn[srs_pkg::CMD_WRITE_BIT]) state_q <= P_EXTWR;
                  else state_q <= P_EXTANS;
               end
            end
            P_GRANT: begin
               if (agentAddr) begin // see [RULE13]
                  if (cmdIn[srs_pkg::CMD_NULL_BIT]) state_q <= retState_q;
                  else if (cmdIn[srs_pkg::CMD_WRITE_BIT]) state_q <= P_EXTWR;
                  else state_q <= P_EXTANS;
               end
            end
            P_EXTANS: state_q <= retState_q; // see [RULE19] [RULE15]
            P_EXTWR: begin
               if (agentData) state_q <= retState_q; // see [RULE15]
            end
            default: state_q <= P_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         addr_q <= '0;
         size_q <= srs_pkg::SZ_WORD;
         isWrite_q <= 1'b0;
         preferExt_q <= 1'b0;
      end else if (state_q == P_IDLE) begin
         if (grantNow) begin
            preferExt_q <= 1'b0;
         end else if (reqValid) begin
            addr_q <= reqAddr; // see [RULE3] [RULE4]
            size_q <= reqSize;
            isWrite_q <= reqWrite;
            preferExt_q <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wordsLeft_q <= 8'h00;
         gap_q <= 3'h0;
      end else begin
         if (state_q == P_ISSUE) wordsLeft_q <= wordsFor(size_q);
         else if (wbReady && wbValid) wordsLeft_q <= wordsLeft_q - 8'h01;
         // cycles after the last data word
         if (state_q == P_WDATA) gap_q <= 3'(srs_pkg::COMPAT_GAP_CYCLES - 1);
         else if (gap_q != 3'h0) gap_q <= gap_q - 3'h1;
      end
   end

   // one-cycle release on a grant and on the self shift after a read
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) release_q <= 1'b0;
      else release_q <= ((state_q == P_IDLE) && grantNow)
         || ((state_q == P_ISSUE) && (extReq && !rdySeen))
         || ((state_q == P_ISSUE) && rdySeen && !isWrite_q); // see [RULE14]
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rspValid <= 1'b0;
         rspData <= '0;
         rspLast <= 1'b0;
         busError <= 1'b0;
         intrWrValid <= 1'b0;
         intrWrData <= '0;
      end else begin
         rspValid <= (state_q == P_WAITRSP) && agentData;
         busError <= (state_q == P_WAITRSP) && agentData
            && cmdIn[srs_pkg::ID_ERR_BIT]; // see [RULE9]
         if ((state_q == P_WAITRSP) && agentData) begin
            rspData <= adIn;
            rspLast <= cmdIn[srs_pkg::ID_LAST_BIT];
         end
         intrWrValid <= (state_q == P_EXTWR) && agentData; // see [RULE21]
         if ((state_q == P_EXTWR) && agentData) intrWrData <= adIn;
      end
   end

   assign bus.busReleaseN = !release_q;
   assign bus.procOe = (state_q == P_ISSUE) || (state_q == P_WDATA)
      || (state_q == P_EXTANS);
   assign bus.processorCycleValidN = !((state_q == P_ISSUE)
      || (state_q == P_WDATA && wbValid) || (state_q == P_EXTANS));
   // no readable resources: external reads get zero data and the error id
   assign bus.procAd = (state_q == P_ISSUE) ? addr_q
      : ((state_q == P_WDATA) ? wbData : '0); // see [RULE20]
   assign bus.procCmd = (state_q == P_ISSUE)
      ? srs_pkg::addrCmd(isWrite_q, 1'b0, size_q) // see [RULE23]
      : ((state_q == P_WDATA) ? srs_pkg::dataId(1'b0, wordsLeft_q == 8'h01)
      : srs_pkg::dataId(state_q == P_EXTANS, 1'b1)); // see [RULE20]
endmodule
`default_nettype wire

/* srs_sysbus_asserts.sv */
// concurrent checks on the shared system interface wires
`timescale 1ns/1ps
`default_nettype none
module srs_sysbus_asserts (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic compatMode,
   input wire logic [srs_pkg::CMD_W-1:0] procCmd,
   input wire logic procOe,
   input wire logic agentOe,
   input wire logic [srs_pkg::CMD_W-1:0] sysCommandBus,
   input wire logic processorCycleValidN,
   input wire logic agentCycleValidN,
   input wire logic readAcceptReadyN,
   input wire logic writeAcceptReadyN,
   input wire logic externalBusRequestN,
   input wire logic busReleaseN
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   logic [1:0] rdSeen_q, wrSeen_q;
   logic rdPend_q, pAddr, issue, pWrLast, aData, aRdReq;
   // ready pin two cycles back
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdSeen_q <= 2'b11;
         wrSeen_q <= 2'b11;
      end else begin
         rdSeen_q <= {rdSeen_q[0], readAcceptReadyN};
         wrSeen_q <= {wrSeen_q[0], writeAcceptReadyN};
      end
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdPend_q <= 1'b0;
      end else if (issue && !procCmd[7]) begin
         rdPend_q <= 1'b1;
      end else if (aData && sysCommandBus[4]) begin
         rdPend_q <= 1'b0;
      end
   end
   assign pAddr = !processorCycleValidN && !procCmd[8];
   assign issue = pAddr && !(procCmd[7] ? wrSeen_q[1] : rdSeen_q[1]);
   assign pWrLast = !processorCycleValidN && procCmd[8] && procCmd[4]
      && !procCmd[5];
   assign aData = !agentCycleValidN && sysCommandBus[8];
   assign aRdReq = !agentCycleValidN && sysCommandBus[8:6] == 3'h0;
   property p_release_pulse;
      $fell(busReleaseN) |=> busReleaseN;
   endproperty
   a_release_pulse: assert property (p_release_pulse)
      else $error("release held low longer than one cycle");
   property p_own_excl;
      !(procOe && agentOe);
   endproperty
   a_own_excl: assert property (p_own_excl)
      else $error("both ends drive the bus");
   property p_repeat_addr;
      pAddr && !issue |=> pAddr || !busReleaseN;
   endproperty
   a_repeat_addr: assert property (p_repeat_addr)
      else $error("address cycle dropped before ready seen");
   property p_read_blocks;
      rdPend_q |-> !pAddr;
   endproperty
   a_read_blocks: assert property (p_read_blocks)
      else $error("request issued while read pending");
   property p_compat_gap;
      compatMode && pWrLast |=> !pAddr [*4];
   endproperty
   a_compat_gap: assert property (p_compat_gap)
      else $error("compat write gap too short");
   property p_ext_read_ans;
      aRdReq |-> ##[1:12] (!processorCycleValidN && procCmd[8]
         && procCmd[5] && procCmd[4]);
   endproperty
   a_ext_read_ans: assert property (p_ext_read_ans)
      else $error("external read not answered with error word");
   property p_valid_driven;
      !processorCycleValidN |-> procOe && sysCommandBus == procCmd;
   endproperty
   a_valid_driven: assert property (p_valid_driven)
      else $error("valid processor cycle not driven");
   property p_rsp_no_ask;
      rdPend_q && aData |-> externalBusRequestN;
   endproperty
   a_rsp_no_ask: assert property (p_rsp_no_ask)
      else $error("read response used bus request");
endmodule
`default_nettype wire

/* srs_sysbus_if.sv */
// shared system interface wires between processor end and agent end
`timescale 1ns/1ps
`default_nettype none
interface srs_sysbus_if;
   logic [srs_pkg::AD_W-1:0] procAd;
   logic [srs_pkg::CMD_W-1:0] procCmd;
   logic procOe;
   logic [srs_pkg::AD_W-1:0] agentAd;
   logic [srs_pkg::CMD_W-1:0] agentCmd;
   logic agentOe;
   logic [srs_pkg::AD_W-1:0] sysAddrDataBus;
   logic [srs_pkg::CMD_W-1:0] sysCommandBus;
   logic processorCycleValidN;
   logic agentCycleValidN;
   logic readAcceptReadyN;
   logic writeAcceptReadyN;
   logic externalBusRequestN;
   logic busReleaseN;

   // shared wires resolved from the enables; an undriven bus reads zero
   assign sysAddrDataBus = procOe ? procAd : (agentOe ? agentAd : '0);
   assign sysCommandBus = procOe ? procCmd : (agentOe ? agentCmd : '0);

   modport proc (
      output procAd, procCmd, procOe, processorCycleValidN, busReleaseN,
      input sysAddrDataBus, sysCommandBus, agentCycleValidN,
      input readAcceptReadyN, writeAcceptReadyN, externalBusRequestN
   );
   modport agent (
      output agentAd, agentCmd, agentOe, agentCycleValidN,
      output readAcceptReadyN, writeAcceptReadyN, externalBusRequestN,
      input sysAddrDataBus, sysCommandBus, processorCycleValidN,
      input busReleaseN
   );
endinterface
`default_nettype wire

/* tb_top.sv */
// self-checking bench: processor end and agent end joined by the bus
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic clk, rst_n, compatMode, reqValid, reqWrite, wrValid, rdAccept;
   logic wrAccept, extValid, aRspValid, aRspErr, aRspLast, reqReady;
   logic wrReady, pRspValid, pRspLast, busError, intrWrValid, extReady;
   logic extRdValid, extRdErr, prqValid, prqWrite, pwValid, pwLast;
   logic aRspReady;
   srs_pkg::srs_size_t reqSize;
   srs_pkg::srs_ext_kind_t extKind;
   logic [2:0] prqSize;
   logic [31:0] reqAddr, wrData, pRspData, intrWrData, extAddr, extData;
   logic [31:0] extRdData, prqAddr, pwData, aRspData;
   logic [39:0] qPrq[$], qPw[$], qRsp[$], qIntr[$], qExt[$], qPlan[$];
   int mismatches = 0;
   int check_count = 0;
   int seed = 32'h1f68cd74;
   srs_sysbus_if bus();
   srs_processor_end srs_processor_end_i (.bus(bus), .rspValid(pRspValid),
      .rspData(pRspData), .rspLast(pRspLast), .*);
   srs_agent_end srs_agent_end_i (.bus(bus), .rspValid(aRspValid),
      .rspReady(aRspReady), .rspData(aRspData), .rspErr(aRspErr),
      .rspLast(aRspLast), .*);
   srs_sysbus_asserts srs_sysbus_asserts_i (.clk(clk), .rst_n(rst_n),
      .compatMode(compatMode), .procCmd(bus.procCmd), .procOe(bus.procOe),
      .agentOe(bus.agentOe), .sysCommandBus(bus.sysCommandBus),
      .processorCycleValidN(bus.processorCycleValidN),
      .agentCycleValidN(bus.agentCycleValidN),
      .readAcceptReadyN(bus.readAcceptReadyN),
      .writeAcceptReadyN(bus.writeAcceptReadyN),
      .externalBusRequestN(bus.externalBusRequestN),
      .busReleaseN(bus.busReleaseN));
   task automatic close_out();
      if (mismatches == 0 && check_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic cmp(input logic [39:0] got, input logic [39:0] exp);
      check_count++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   // valid stays high on return
   task automatic hs(ref logic v, ref logic rdy);
      int n;
      n = 0;
      v = 1'b1;
      #1;
      while (rdy !== 1'b1 && n < 500) begin
         @(negedge clk);
         #1;
         n++;
      end
      if (n == 500) mismatches++;
      @(negedge clk);
   endtask
   task automatic procReq(input logic w, input srs_pkg::srs_size_t sz,
      input logic [31:0] a);
      int n;
      n = sz == srs_pkg::SZ_BLOCK ? srs_pkg::BLOCK_WORDS :
         sz == srs_pkg::SZ_DWORD ? srs_pkg::DWORD_WORDS : 1;
      @(negedge clk);
      reqWrite = w;
      reqSize = sz;
      reqAddr = a;
      qPrq.push_back({w, 3'(sz), a});
      if (!w) qPlan.push_back({a[31], 4'(n)});
      hs(reqValid, reqReady);
      reqValid = 1'b0;
      for (int i = 0; i < n && w; i++) begin
         wrData = $random(seed);
         qPw.push_back({i + 1 == n, wrData});
         hs(wrValid, wrReady);
      end
      wrValid = 1'b0;
   endtask
   task automatic extReq(input srs_pkg::srs_ext_kind_t k);
      @(negedge clk);
      extKind = k;
      extAddr = $random(seed);
      extData = $random(seed);
      if (k == srs_pkg::EXT_READ) qExt.push_back(40'h1);
      if (k == srs_pkg::EXT_WRITE) qIntr.push_back({8'h0, extData});
      hs(extValid, extReady);
      // write data held one more cycle
      @(negedge clk);
      extValid = 1'b0;
   endtask
   task automatic drain();
      int n;
      n = 0;
      while (qPrq.size() + qPw.size() + qRsp.size() + qIntr.size()
         + qExt.size() + qPlan.size() > 0 && n < 3000) begin
         @(negedge clk);
         n++;
      end
      if (n == 3000) mismatches++;
      repeat (8) @(negedge clk);
   endtask
   always @(posedge clk) if (rst_n) begin
      if (prqValid) cmp({prqWrite, prqSize, prqAddr}, qPrq.pop_front());
      if (pwValid) cmp({pwLast, pwData}, qPw.pop_front());
      if (pRspValid) cmp({busError, pRspLast, pRspData}, qRsp.pop_front());
      if (intrWrValid) cmp(intrWrData, qIntr.pop_front());
      if (extRdValid) cmp(extRdErr, qExt.pop_front());
   end
   // the agent throttles each request type on its own
   always @(negedge clk) if (rst_n) begin
      rdAccept = ($random(seed) & 3) != 0;
      wrAccept = ($random(seed) & 3) != 0;
   end
   initial begin : responder
      logic [39:0] p;
      aRspValid = 1'b0;
      aRspErr = 1'b0;
      aRspLast = 1'b0;
      aRspData = 32'h0;
      forever begin
         @(negedge clk);
         if (prqValid && !prqWrite) begin
            p = qPlan.pop_front();
            repeat ($unsigned($random(seed)) % 6) @(negedge clk);
            for (int i = 0; i < int'(p[3:0]); i++) begin
               aRspData = $random(seed);
               aRspErr = p[4];
               aRspLast = i + 1 == int'(p[3:0]);
               qRsp.push_back({aRspErr, aRspLast, aRspData});
               hs(aRspValid, aRspReady);
            end
            aRspValid = 1'b0;
         end
      end
   end
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   initial begin
      #(20 * 60000);
      mismatches++;
      close_out();
   end
   initial begin
      rst_n = 1'b0;
      {compatMode, reqValid, reqWrite, wrValid, rdAccept, wrAccept} = '0;
      extValid = 1'b0;
      reqSize = srs_pkg::SZ_WORD;
      extKind = srs_pkg::EXT_NULL;
      {reqAddr, wrData, extAddr, extData} = '0;
      repeat (8) @(negedge clk);
      rst_n = 1'b1;
      for (int s = 0; s < 5; s++) begin
         procReq(1'b0, srs_pkg::srs_size_t'(s), $random(seed) & 32'h7fffffff);
         procReq(1'b1, srs_pkg::srs_size_t'(s), $random(seed));
      end
      procReq(1'b0, srs_pkg::SZ_WORD, 32'h80000010);
      drain();
      compatMode = 1'b1;
      fork
         for (int i = 0; i < 14; i++) begin
            procReq($random(seed), srs_pkg::srs_size_t'($unsigned($random(seed)) % 5), $random(seed));
         end
         for (int i = 0; i < 9; i++) begin
            extReq(srs_pkg::srs_ext_kind_t'(i % 3));
         end
      join
      drain();
      close_out();
   end
endmodule
`default_nettype wire
